// [fsr_pkg.sv]
package fsr_pkg;

  localparam int FSR_ADDR_W = 20;
  localparam int FSR_DATA_W = 16;

  // avalon register offsets (byte addresses)
  localparam logic [3:0] FSR_REG_CTRL = 4'h0;
  localparam logic [3:0] FSR_REG_ADDR = 4'h4;
  localparam logic [3:0] FSR_REG_DATA = 4'h8;
  localparam logic [3:0] FSR_REG_STAT = 4'hC;

  // ctrl fields
  localparam int FSR_CTRL_GO = 0;
  localparam int FSR_CTRL_OP_LO = 1;
  localparam int FSR_CTRL_OP_HI = 2;
  localparam int FSR_CTRL_ALG = 3;

  // status fields
  localparam int FSR_ST_BUSY = 0;
  localparam int FSR_ST_DONE = 1;
  localparam int FSR_ST_FAIL = 2;
  localparam int FSR_ST_RDY = 3;
  localparam int FSR_ST_SUSP = 4;
  localparam int FSR_ST_SECT = 5;

  // operations
  localparam logic [1:0] FSR_OP_WRITE = 2'h0;
  localparam logic [1:0] FSR_OP_READ = 2'h1;
  localparam logic [1:0] FSR_OP_POLL = 2'h2;
  localparam logic [1:0] FSR_OP_RESET = 2'h3;

  // status bit positions on the data bus
  localparam int FSR_BIT_COMPLETION = 7;
  localparam int FSR_BIT_GTOGGLE = 6;
  localparam int FSR_BIT_TIMEOUT = 5;
  localparam int FSR_BIT_STOGGLE = 2;

  localparam logic [15:0] FSR_RESET_CMD = 16'h00F0;

  // bus cycle timing
  localparam int FSR_CLK_MHZ = 40;
  localparam int FSR_T_STROBE_NS = 100;
  localparam int FSR_STROBE_CYC =
    (FSR_T_STROBE_NS * FSR_CLK_MHZ + 999) / 1000;
  localparam int FSR_CNT_W = 4;

endpackage : fsr_pkg

// [fsr_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module fsr_sync
  import fsr_pkg::*;
#(
  parameter int W = 1
)
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : fsr_sync
`default_nettype wire

// [fsr_strobe.sv]
`timescale 1ns/1ps
`default_nettype none
module fsr_strobe
  import fsr_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic start,
  output logic tick,
  output logic active
);
  // one pulse when a strobe phase has lasted its least width
  logic [FSR_CNT_W-1:0] cnt_r;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_r <= '0;
      active <= 1'b0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= 1'b0;
      if (start)
      begin
        cnt_r <= '0;
        active <= 1'b1;
      end
      else if (active)
      begin
        if (cnt_r == FSR_CNT_W'(FSR_STROBE_CYC - 1))
        begin
          active <= 1'b0;
          tick <= 1'b1;
        end
        else
          cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule : fsr_strobe
`default_nettype wire

// [fsr_ctrl.sv]
// The Avalon-MM slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module fsr_ctrl
  import fsr_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [FSR_ADDR_W-1:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic [FSR_DATA_W-1:0] flash_dq_o,
  output logic flash_dq_oe_n,
  input wire logic [FSR_DATA_W-1:0] flash_dq_i,
  input wire logic ready_busy_n
);
  typedef enum {
    FSR_IDLE, FSR_WR_LOW, FSR_WR_HIGH, FSR_RD_LOW, FSR_RD_TAKE,
    FSR_RD_HIGH, FSR_EVAL, FSR_FINISH
  } fsr_state_t;

  fsr_state_t state_r;
  logic [1:0] op_r;
  logic alg_r;
  logic [FSR_ADDR_W-1:0] addr_r;
  logic [FSR_DATA_W-1:0] wdata_r;
  logic [FSR_DATA_W-1:0] rdata_r;
  logic [FSR_DATA_W-1:0] prev_r;
  logic [1:0] nreads_r;
  logic fail_seen_r;
  logic settle_r;
  logic busy_r;
  logic done_r;
  logic fail_r;
  logic susp_r;
  logic sect_r;
  logic go;
  logic tick;
  logic strobe_active;
  logic start_strobe;
  logic [FSR_DATA_W-1:0] dq_s;
  logic rb_s;
  logic cur_tog;
  logic prev_tog;
  logic cur_tmo;
  logic cur_pol;
  logic exp_pol;
  logic toggling;

  // pins arrive asynchronously to mclk
  fsr_sync #(.W(FSR_DATA_W + 1)) u_sync (
    .mclk(mclk),
    .nrst(nrst),
    .d({ready_busy_n, flash_dq_i}),
    .q({rb_s, dq_s})
  );

  fsr_strobe u_strobe (
    .mclk(mclk),
    .nrst(nrst),
    .start(start_strobe),
    .tick(tick),
    .active(strobe_active)
  );

  assign go = avs_write && !avs_waitrequest &&
    avs_address == FSR_REG_CTRL && avs_writedata[FSR_CTRL_GO] &&
    state_r == FSR_IDLE;

  assign start_strobe = (state_r == FSR_WR_LOW || state_r == FSR_RD_LOW ||
    state_r == FSR_WR_HIGH || state_r == FSR_RD_HIGH) && !strobe_active &&
    !tick;

  assign cur_tog = rdata_r[FSR_BIT_GTOGGLE];
  assign prev_tog = prev_r[FSR_BIT_GTOGGLE];
  assign cur_tmo = rdata_r[FSR_BIT_TIMEOUT];
  assign cur_pol = rdata_r[FSR_BIT_COMPLETION];
  // a data poll (alg set) expects bit 7 of the data reg; an erase poll expects one only if that bit is written as one
  assign exp_pol = wdata_r[FSR_BIT_COMPLETION];
  assign toggling = (cur_tog != prev_tog);

  // avalon slave: one wait cycle per access, readdata registered
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= !(avs_waitrequest && (avs_read || avs_write));
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      avs_readdata <= '0;
    else if (avs_read && avs_waitrequest)
    begin
      case (avs_address)
        FSR_REG_CTRL:
          avs_readdata <= {28'h0000000, alg_r, op_r, 1'b0};
        FSR_REG_ADDR:
          avs_readdata <= {12'h000, addr_r};
        FSR_REG_DATA:
          avs_readdata <= {16'h0000, rdata_r};
        FSR_REG_STAT:
          avs_readdata <= {26'h0000000, sect_r, susp_r, rb_s, fail_r,
            done_r, busy_r};
        default:
          avs_readdata <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      op_r <= FSR_OP_WRITE;
      alg_r <= 1'b0;
      addr_r <= '0;
      wdata_r <= '0;
    end
    else if (avs_write && !avs_waitrequest && state_r == FSR_IDLE)
    begin
      case (avs_address)
        FSR_REG_CTRL:
        begin
          op_r <= avs_writedata[FSR_CTRL_OP_HI:FSR_CTRL_OP_LO];
          alg_r <= avs_writedata[FSR_CTRL_ALG];
        end
        FSR_REG_ADDR:
          addr_r <= avs_writedata[FSR_ADDR_W-1:0];
        FSR_REG_DATA:
          wdata_r <= avs_writedata[FSR_DATA_W-1:0];
        default:
          ;
      endcase
    end
  end

  // sequencer
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= FSR_IDLE;
      nreads_r <= '0;
      fail_seen_r <= 1'b0;
      settle_r <= 1'b0;
      prev_r <= '0;
      rdata_r <= '0;
    end
    else
    begin
      case (state_r)
        FSR_IDLE:
          if (go)
          begin
            // a fresh poll always starts from the first read
            nreads_r <= '0;
            fail_seen_r <= 1'b0;
            settle_r <= 1'b0;
            if (avs_writedata[FSR_CTRL_OP_HI:FSR_CTRL_OP_LO] ==
              FSR_OP_WRITE ||
              avs_writedata[FSR_CTRL_OP_HI:FSR_CTRL_OP_LO] == FSR_OP_RESET)
              state_r <= FSR_WR_LOW;
            else
              state_r <= FSR_RD_LOW;
          end
        FSR_WR_LOW:
          if (tick)
            state_r <= FSR_WR_HIGH;
        FSR_WR_HIGH:
          if (tick)
            state_r <= FSR_FINISH;
        FSR_RD_LOW:
          if (tick)
            state_r <= FSR_RD_TAKE;
        FSR_RD_TAKE:
        begin
          // sample after the synchroniser has caught the settled bus
          prev_r <= rdata_r;
          rdata_r <= dq_s;
          state_r <= FSR_RD_HIGH;
        end
        FSR_RD_HIGH:
          if (tick)
            state_r <= (op_r == FSR_OP_POLL) ? FSR_EVAL : FSR_FINISH;
        FSR_EVAL:
        begin
          if (nreads_r != 2'h3)
            nreads_r <= nreads_r + 2'h1;
          settle_r <= alg_r && cur_pol == exp_pol;
          if (alg_r)
          begin
            // completion polling at the address held in the addr reg
            if (cur_pol == exp_pol)
              // one more read so the other bits have settled
              state_r <= settle_r ? FSR_FINISH : FSR_RD_LOW;
            else if (cur_tmo && fail_seen_r)
              state_r <= FSR_FINISH;
            else
            begin
              fail_seen_r <= cur_tmo;
              state_r <= FSR_RD_LOW;
            end
          end
          else if (nreads_r == 2'h0)
            state_r <= FSR_RD_LOW;
          else if (!toggling)
            state_r <= FSR_FINISH;
          else if (cur_tmo && fail_seen_r)
            state_r <= FSR_FINISH;
          else
          begin
            fail_seen_r <= cur_tmo;
            state_r <= FSR_RD_LOW;
          end
        end
        FSR_FINISH:
          state_r <= FSR_IDLE;
        default:
          state_r <= FSR_IDLE;
      endcase
    end
  end

  // status register; done and fail latch per operation
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      fail_r <= 1'b0;
      susp_r <= 1'b0;
      sect_r <= 1'b0;
    end
    else if (go)
    begin
      busy_r <= 1'b1;
      done_r <= 1'b0;
      fail_r <= 1'b0;
    end
    else if (state_r == FSR_FINISH)
    begin
      busy_r <= 1'b0;
      done_r <= 1'b1;
      if (op_r == FSR_OP_POLL)
      begin
        // fail only when still busy after timeout bit rose
        fail_r <= fail_seen_r && cur_tmo &&
          (alg_r ? (cur_pol != exp_pol) : toggling);
        // sector toggling without global toggling means suspended
        sect_r <= rdata_r[FSR_BIT_STOGGLE] !=
          prev_r[FSR_BIT_STOGGLE];
        susp_r <= !toggling && (rdata_r[FSR_BIT_STOGGLE] !=
          prev_r[FSR_BIT_STOGGLE]);
      end
    end
  end

  // pins; reset command is a write of the fixed reset datum
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      flash_addr <= '0;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_dq_o <= '0;
      flash_dq_oe_n <= 1'b1;
    end
    else
    begin
      flash_addr <= addr_r;
      flash_dq_o <= (op_r == FSR_OP_RESET) ? FSR_RESET_CMD : wdata_r;
      flash_ce_n <= !(state_r == FSR_WR_LOW || state_r == FSR_WR_HIGH ||
        state_r == FSR_RD_LOW || state_r == FSR_RD_TAKE);
      flash_we_n <= !(state_r == FSR_WR_LOW);
      flash_oe_n <= !(state_r == FSR_RD_LOW || state_r == FSR_RD_TAKE);
      flash_dq_oe_n <= !(state_r == FSR_WR_LOW || state_r == FSR_WR_HIGH);
    end
  end
endmodule : fsr_ctrl
`default_nettype wire

// [fsr_ctrl_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module fsr_ctrl_chk
  import fsr_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [FSR_ADDR_W-1:0] flash_addr,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic [FSR_DATA_W-1:0] flash_dq_o,
  input wire logic flash_dq_oe_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("late answer");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("long answer");
  a_hole_zero: assert property (!avs_waitrequest && avs_read &&
    avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0) else $error("hole");
  a_strobe_excl: assert property (!flash_oe_n || !flash_we_n
    |-> !flash_ce_n && (flash_oe_n || flash_we_n)) else $error("strobes");
  a_no_fight: assert property (!flash_oe_n |-> flash_dq_oe_n)
    else $error("contention");
  a_we_width: assert property ($fell(flash_we_n) |-> !flash_we_n [*4])
    else $error("short write");
  a_oe_width: assert property ($fell(flash_oe_n) |-> !flash_oe_n [*4])
    else $error("short read");
  a_addr_hold: assert property (!flash_oe_n && $past(!flash_oe_n)
    |-> $stable(flash_addr)) else $error("addr moved");
  a_wdata_hold: assert property (!flash_we_n && $past(!flash_we_n)
    |-> $stable(flash_dq_o) && !flash_dq_oe_n) else $error("data moved");
  cover property ($fell(flash_we_n));
  cover property ($fell(flash_oe_n) ##[1:20] $fell(flash_oe_n));
  cover property (!avs_waitrequest && avs_read);
endmodule : fsr_ctrl_chk
bind fsr_ctrl fsr_ctrl_chk u_chk (.mclk, .nrst, .avs_address, .avs_read,
  .avs_write, .avs_readdata, .avs_waitrequest, .flash_addr, .flash_ce_n,
  .flash_oe_n, .flash_we_n, .flash_dq_o, .flash_dq_oe_n);
`default_nettype wire

// [fsr_flash_model.sv]
`timescale 1ns/1ps
`default_nettype none
module fsr_flash_model
  import fsr_pkg::*;
(
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [FSR_DATA_W-1:0] dq_o,
  input wire logic fail,
  input wire logic [3:0] nreads,
  input wire logic susp,
  output logic [FSR_DATA_W-1:0] dq_i,
  output logic ready_busy_n
);
  int left = 0;
  logic armed = 1'b0;
  logic tog = 1'b0;
  logic stog = 1'b0;
  logic er = 1'b0;
  logic [15:0] mem = 16'h0000;
  logic [15:0] word;
  // armed so the reset edge of the strobe starts nothing
  always @(negedge we_n) armed = 1'b1;
  always @(posedge we_n)
    if (armed)
    begin
      armed = 1'b0;
      tog = 1'b0;
      stog = 1'b0;
      er = (dq_o == 16'h0030);
      left = (dq_o == FSR_RESET_CMD) ? 0 : int'(nreads);
      if (dq_o != FSR_RESET_CMD)
        mem = er ? 16'hFFFF : dq_o;
    end
  // a failed run never ends on its own
  always @(posedge oe_n)
    if (left > 0)
    begin
      // suspend freezes the global toggle and the erase itself
      if (!susp)
        tog = ~tog;
      stog = ~stog;
      if (!fail && !susp)
        left = left - 1;
    end
  always_comb
    word = (left > 0) ?
      {8'h00, susp | ~mem[7], tog, fail, 2'h0, er & stog, 2'h0} :
      mem;
  // released bus shows the inverse so stale data cannot pass
  assign dq_i = !oe_n ? word : ~word;
  assign ready_busy_n = (left > 0 && !susp) ? 1'b0 : 1'b1;
endmodule : fsr_flash_model
`default_nettype wire

// [tb_flash_write_status_reporting.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_flash_write_status_reporting
  import fsr_pkg::*;
;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe_n;
  logic ready_busy_n;
  logic fail = 1'b0;
  logic susp = 1'b0;
  logic [3:0] nreads = 4'h3;
  logic [FSR_ADDR_W-1:0] flash_addr;
  logic [FSR_DATA_W-1:0] flash_dq_o, flash_dq_i;
  int errors = 0;
  int checks_done = 0;
  int cyc = 0;
  always #12.5 mclk = ~mclk;
  fsr_ctrl uut (.mclk, .nrst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .flash_addr,
    .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_dq_o, .flash_dq_oe_n,
    .flash_dq_i, .ready_busy_n);
  fsr_flash_model u_flash (.oe_n(flash_oe_n), .we_n(flash_we_n),
    .dq_o(flash_dq_o), .fail, .nreads, .susp, .dq_i(flash_dq_i),
    .ready_busy_n);
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      errors++;
      finish_test();
    end
  end
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic av(logic w, logic [3:0] a, logic [31:0] d,
    output logic [31:0] q);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0)
      @(posedge mclk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : av
  task automatic wr(logic [3:0] a, logic [31:0] d);
    logic [31:0] q;
    av(1'b1, a, d, q);
  endtask : wr
  task automatic rd(logic [3:0] a, output logic [31:0] q);
    av(1'b0, a, 32'h0, q);
  endtask : rd
  task automatic op(logic [1:0] o, logic alg);
    logic [31:0] s;
    wr(FSR_REG_CTRL, 32'(alg) << FSR_CTRL_ALG | 32'(o) << FSR_CTRL_OP_LO | 1);
    s = 32'h1;
    while (s[FSR_ST_BUSY] !== 1'b0)
      rd(FSR_REG_STAT, s);
  endtask : op
  initial
  begin
    logic [31:0] s;
    logic [15:0] d;
    logic [19:0] a;
    void'($urandom(32'h8C3E));
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    rd(4'h2, s);
    chk("unmapped", 32'h0, s);
    rd(FSR_REG_STAT, s);
    chk("idle_rdy", 32'h1, 32'(s[FSR_ST_RDY]));
    for (int i = 0; i < 6; i++)
    begin
      d = 16'($urandom);
      a = 20'($urandom);
      if (d == FSR_RESET_CMD || d == 16'h0030)
        d = 16'h1234;
      if (i >= 4)
        d = 16'h0030;
      fail <= i[1] & ~i[2];
      wr(FSR_REG_ADDR, 32'(a));
      wr(FSR_REG_DATA, 32'(d));
      op(FSR_OP_WRITE, 1'b0);
      rd(FSR_REG_STAT, s);
      chk("busy_pin", 32'h0, 32'(s[FSR_ST_RDY]));
      if (i == 4)
      begin
        d = 16'hFFFF;
        wr(FSR_REG_DATA, 32'h80);
      end
      // last pass: erase suspended, toggle polling
      susp <= (i == 5);
      op(FSR_OP_POLL, (i[0] | i[2]) && i != 5);
      chk("addr_pin", 32'(a), 32'(flash_addr));
      rd(FSR_REG_STAT, s);
      chk("fail", 32'(fail), 32'(s[FSR_ST_FAIL]));
      if (fail)
      begin
        op(FSR_OP_RESET, 1'b0);
        rd(FSR_REG_STAT, s);
        chk("reset_rdy", 32'h1, 32'(s[FSR_ST_RDY]));
      end
      else if (susp)
      begin
        chk("susp", 32'h1, 32'(s[FSR_ST_SUSP]));
        chk("sect", 32'h1, 32'(s[FSR_ST_SECT]));
        chk("susp_rdy", 32'h1, 32'(s[FSR_ST_RDY]));
        rd(FSR_REG_DATA, s);
        chk("susp_pol", 32'h1, 32'(s[FSR_BIT_COMPLETION]));
      end
      else
      begin
        chk("done", 32'h1, 32'(s[FSR_ST_DONE]));
        rd(FSR_REG_DATA, s);
        chk("poll_word", 32'(d), {16'h0, s[15:0]});
        op(FSR_OP_READ, 1'b0);
        rd(FSR_REG_DATA, s);
        chk("read_word", 32'(d), {16'h0, s[15:0]});
      end
    end
    finish_test();
  end
endmodule : tb_flash_write_status_reporting
`default_nettype wire
